//--- design/fantm_top.sv
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "fantm_defs.svh"
module fantm_top #(
   parameter int BASE_HZ0 = 62500,
   parameter int BASE_HZ1 = 31250,
   parameter int BASE_HZ2 = 15625,
   parameter int BASE_HZ3 = 7812
) (
   input wire logic pclk, // APB clock, 200 MHz.
   input wire logic presetn, // Standby power-on reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB write direction.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic [1:0] fan_tach // Tach pins, fan one at bit 0.
);
   // ****************************************
   // Counting rates
   // ****************************************
   localparam logic [19:0] BASE_P0 = 20'(`FANTM_CLK_HZ / BASE_HZ0);
   localparam logic [19:0] BASE_P1 = 20'(`FANTM_CLK_HZ / BASE_HZ1);
   localparam logic [19:0] BASE_P2 = 20'(`FANTM_CLK_HZ / BASE_HZ2);
   localparam logic [19:0] BASE_P3 = 20'(`FANTM_CLK_HZ / BASE_HZ3);

   logic [7:0] cfg_reg;
   logic [7:0] cfg_next;
   logic [7:0] sel_reg;
   logic [7:0] sel_next;
   logic [7:0] preload_reg;
   logic [7:0] preload_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] sync3_reg;
   logic [1:0] pulse_edge;
   logic [1:0] tick;
   logic [1:0] valid;
   logic [7:0] live_count [2];
   logic [7:0] tach_count [2];
   logic setup;
   logic access_done;
   logic mapped;
   logic preload_wr;

   // ****************************************
   // Tach pin synchroniser
   // ****************************************
   // The third stage only remembers the last level so an edge can be seen.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
         sync3_reg <= 2'h0;
      end else begin
         sync1_reg <= fan_tach;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign pulse_edge = sync2_reg & ~sync3_reg;

   // ****************************************
   // Per-fan rate and counter
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_fan
         fantm_tick_gen #(
            .PW(20),
            .BASE0(BASE_P0),
            .BASE1(BASE_P1),
            .BASE2(BASE_P2),
            .BASE3(BASE_P3)
         ) u_tick (
            .pclk(pclk),
            .presetn(presetn),
            .clk_src(cfg_reg[`FANTM_CFG_SRC_BIT + gi]),
            .clk_sel(sel_reg[gi]),
            .clk_mul(cfg_reg[`FANTM_CFG_MUL_BIT + gi]),
            .div_code(fantm_pkg::fantm_div_t'(cfg_reg[`FANTM_CFG_DIV_LSB + 2*gi +: 2])),
            .tick(tick[gi])
         );
         fantm_tach_counter #(
            .CW(8)
         ) u_cnt (
            .pclk(pclk),
            .presetn(presetn),
            .tick(tick[gi]),
            .pulse_edge(pulse_edge[gi]),
            .restart(preload_wr),
            .preload(preload_reg),
            .live_count(live_count[gi]),
            .tach_count(tach_count[gi]),
            .valid(valid[gi])
         );
      end
   endgenerate

   // ****************************************
   // APB slave
   // ****************************************
   // Zero-wait slave: ready rises for the access phase right after setup.
   assign setup = psel && !penable;
   assign access_done = psel && penable && pready_reg;
   assign preload_wr = access_done && pwrite && paddr == `FANTM_OFF_PRELOAD && !pslverr_reg;

   always_comb begin
      case (paddr)
         `FANTM_OFF_CFG, `FANTM_OFF_TACH1, `FANTM_OFF_TACH2,
         `FANTM_OFF_SEL, `FANTM_OFF_PRELOAD, `FANTM_OFF_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      cfg_next = cfg_reg;
      sel_next = sel_reg;
      preload_next = preload_reg;
      prdata_next = prdata_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      if (setup) begin
         pready_next = 1'b1;
         pslverr_next = !mapped;
         case (paddr)
            `FANTM_OFF_CFG: prdata_next = {24'h0, cfg_reg};
            `FANTM_OFF_TACH1: prdata_next = {24'h0, tach_count[0]};
            `FANTM_OFF_TACH2: prdata_next = {24'h0, tach_count[1]};
            `FANTM_OFF_SEL: prdata_next = {30'h0, sel_reg[1:0]};
            `FANTM_OFF_PRELOAD: prdata_next = {24'h0, preload_reg};
            `FANTM_OFF_STATUS: prdata_next = {30'h0, valid};
            default: prdata_next = 32'h0;
         endcase
      end
      // Writes land only at the edge that completes the access phase.
      if (access_done && pwrite) begin
         case (paddr)
            `FANTM_OFF_CFG: cfg_next = pwdata[7:0];
            `FANTM_OFF_SEL: sel_next = {6'h0, pwdata[1:0]};
            `FANTM_OFF_PRELOAD: preload_next = pwdata[7:0];
            default: cfg_next = cfg_reg;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= `FANTM_CFG_RST;
         sel_reg <= `FANTM_SEL_RST;
         preload_reg <= `FANTM_PRELOAD_RST;
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         sel_reg <= sel_next;
         preload_reg <= preload_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // ****************************************
   // Checks
   // ****************************************
   function automatic logic [22:0] exp_period(input logic [7:0] c, input logic [7:0] s, input int f);
      logic [19:0] b;
      logic [22:0] p;
      b = ({c[`FANTM_CFG_SRC_BIT + f], s[f]} == 2'b00) ? BASE_P0 :
          ({c[`FANTM_CFG_SRC_BIT + f], s[f]} == 2'b01) ? BASE_P1 :
          ({c[`FANTM_CFG_SRC_BIT + f], s[f]} == 2'b10) ? BASE_P2 : BASE_P3;
      p = {3'h0, (c[`FANTM_CFG_MUL_BIT + f] ? (b >> 1) : b)};
      p = p << c[`FANTM_CFG_DIV_LSB + 2*f +: 2];
      exp_period = (p == '0) ? 23'h1 : p;
   endfunction : exp_period

   logic [22:0] gap_reg [2];
   logic [1:0] stable_reg;
   logic cfg_wr_seen_reg;
   logic [1:0] edge_seen_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_reg[0] <= '0;
         gap_reg[1] <= '0;
         stable_reg <= 2'h0;
         cfg_wr_seen_reg <= 1'b0;
         edge_seen_reg <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            gap_reg[i] <= tick[i] ? 23'h1 : gap_reg[i] + 23'h1;
            if (cfg_next != cfg_reg || sel_next != sel_reg) begin
               stable_reg[i] <= 1'b0;
            end else if (tick[i]) begin
               stable_reg[i] <= 1'b1;
            end
            if (pulse_edge[i]) begin
               edge_seen_reg[i] <= 1'b1;
            end
         end
         if (access_done && pwrite && paddr == `FANTM_OFF_CFG) begin
            cfg_wr_seen_reg <= 1'b1;
         end
      end
   end

   a_cfg_default: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg_wr_seen_reg |-> cfg_reg == `FANTM_CFG_RST)
      else $error("config left its reset value");
   // Tick spacing is judged only after one whole interval has run under unchanged settings.
   a_fan_one_rate: assert property (@(posedge pclk) disable iff (!presetn)
      tick[0] && stable_reg[0] |-> gap_reg[0] == exp_period(cfg_reg, sel_reg, 0))
      else $error("fan one tick spacing wrong");
   a_fan_two_rate: assert property (@(posedge pclk) disable iff (!presetn)
      tick[1] && stable_reg[1] |-> gap_reg[1] == exp_period(cfg_reg, sel_reg, 1))
      else $error("fan two tick spacing wrong");
   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready && (pslverr == !$past(mapped)))
      else $error("apb answer missing");
   a_preload_invalid: assert property (@(posedge pclk) disable iff (!presetn)
      preload_wr |=> valid == 2'h0)
      else $error("valid kept after preload write");
   a_read_tach_one: assert property (@(posedge pclk) disable iff (!presetn)
      setup && paddr == `FANTM_OFF_TACH1 |=> prdata == {24'h0, $past(tach_count[0])})
      else $error("fan one count read wrong");
   a_read_tach_two: assert property (@(posedge pclk) disable iff (!presetn)
      setup && paddr == `FANTM_OFF_TACH2 |=> prdata == {24'h0, $past(tach_count[1])})
      else $error("fan two count read wrong");
   a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup && paddr == `FANTM_OFF_STATUS |=> prdata == {30'h0, $past(valid)})
      else $error("status read wrong");
   a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
      access_done && pwrite && paddr == `FANTM_OFF_CFG |=> cfg_reg == $past(pwdata[7:0]))
      else $error("config write lost");
   a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
      access_done && pwrite && paddr == `FANTM_OFF_SEL |=> sel_reg == {6'h0, $past(pwdata[1:0])})
      else $error("select write lost");
   a_unmapped_data: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !mapped |=> prdata == 32'h0 && pslverr)
      else $error("unmapped read not refused");
   a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error without ready");
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready && !setup |=> !pready)
      else $error("ready stood too long");

   generate
      for (gi = 0; gi < 2; gi++) begin : g_chk
         a_count_latch: assert property (@(posedge pclk) disable iff (!presetn)
            pulse_edge[gi] |=> tach_count[gi] == $past(live_count[gi]) && live_count[gi] == $past(preload_reg))
            else $error("count not latched at pulse end");
         a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
            tick[gi] && !pulse_edge[gi] && live_count[gi] != `FANTM_TACH_MAX |=>
            live_count[gi] == $past(live_count[gi]) + 8'h01)
            else $error("count did not step");
         a_count_sat: assert property (@(posedge pclk) disable iff (!presetn)
            live_count[gi] == `FANTM_TACH_MAX && !pulse_edge[gi] |=> live_count[gi] == `FANTM_TACH_MAX)
            else $error("count wrapped");
         a_count_reset: assert property (@(posedge pclk) disable iff (!presetn)
            !edge_seen_reg[gi] |-> tach_count[gi] == `FANTM_TACH_RST)
            else $error("count not zero");
         a_hold_between: assert property (@(posedge pclk) disable iff (!presetn)
            !pulse_edge[gi] |=> $stable(tach_count[gi]))
            else $error("count moved mid pulse");
         a_valid_rise: assert property (@(posedge pclk) disable iff (!presetn)
            $rose(valid[gi]) |-> $past(pulse_edge[gi]))
            else $error("valid rose without a pulse end");
      end
   endgenerate

   // ****************************************
   // Coverage
   // ****************************************
   c_latch_one: cover property (@(posedge pclk) disable iff (!presetn) pulse_edge[0] && live_count[0] != 8'h00);
   c_sat_two: cover property (@(posedge pclk) disable iff (!presetn) live_count[1] == `FANTM_TACH_MAX);
   c_preload: cover property (@(posedge pclk) disable iff (!presetn) preload_wr ##[1:1000] valid[1]);
   c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule : fantm_top

//--- design/fantm_defs.svh
`ifndef FANTM_DEFS_SVH
`define FANTM_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define FANTM_OFF_CFG 8'h00
`define FANTM_OFF_TACH1 8'h04
`define FANTM_OFF_TACH2 8'h08
`define FANTM_OFF_SEL 8'h0c
`define FANTM_OFF_PRELOAD 8'h10
`define FANTM_OFF_STATUS 8'h14

// ****************************************
// Field positions and reset values
// ****************************************
`define FANTM_CFG_SRC_BIT 0
`define FANTM_CFG_MUL_BIT 2
`define FANTM_CFG_DIV_LSB 4
`define FANTM_CFG_RST 8'h50
`define FANTM_SEL_RST 8'h00
`define FANTM_PRELOAD_RST 8'h00
`define FANTM_TACH_RST 8'h00
`define FANTM_TACH_MAX 8'hff
`define FANTM_VALID_PULSES 2'h2

// ****************************************
// Timing
// ****************************************
`define FANTM_CLK_HZ 200000000

`endif

//--- design/fantm_pkg.sv
package fantm_pkg;
   typedef enum logic [1:0] {
      FANTM_DIV_1 = 2'b00,
      FANTM_DIV_2 = 2'b01,
      FANTM_DIV_4 = 2'b10,
      FANTM_DIV_8 = 2'b11
   } fantm_div_t;
endpackage : fantm_pkg

//--- design/fantm_tick_gen.sv
`timescale 1ns/1ps
`include "fantm_defs.svh"
module fantm_tick_gen #(
   parameter int PW = 20,
   parameter logic [19:0] BASE0 = 20'h00c80,
   parameter logic [19:0] BASE1 = 20'h01900,
   parameter logic [19:0] BASE2 = 20'h03200,
   parameter logic [19:0] BASE3 = 20'h06400
) (
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic clk_src, // Clock source select bit.
   input wire logic clk_sel, // Clock select bit of the speed register.
   input wire logic clk_mul, // Doubles the counting rate.
   input wire fantm_pkg::fantm_div_t div_code, // Count divisor code.
   output logic tick // One-cycle counting pulse.
);
   logic [PW+2:0] period;
   logic [PW+2:0] cnt_reg;
   logic [PW+2:0] cnt_next;
   logic tick_reg;
   logic tick_next;
   logic [PW-1:0] base;

   always_comb begin
      case ({clk_src, clk_sel})
         2'b00: base = BASE0[PW-1:0];
         2'b01: base = BASE1[PW-1:0];
         2'b10: base = BASE2[PW-1:0];
         default: base = BASE3[PW-1:0];
      endcase
      period = {3'h0, (clk_mul ? (base >> 1) : base)};
      case (div_code)
         fantm_pkg::FANTM_DIV_1: period = period;
         fantm_pkg::FANTM_DIV_2: period = period << 1;
         fantm_pkg::FANTM_DIV_4: period = period << 2;
         default: period = period << 3;
      endcase
      if (period == '0) begin
         period = {{(PW+2){1'b0}}, 1'b1};
      end
      // A shortened period restarts the count rather than running past it.
      if (cnt_reg + 1'b1 >= period) begin
         cnt_next = '0;
         tick_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + 1'b1;
         tick_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule : fantm_tick_gen

//--- design/fantm_tach_counter.sv
`timescale 1ns/1ps
`include "fantm_defs.svh"
module fantm_tach_counter #(
   parameter int CW = 8
) (
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic tick, // Counting pulse.
   input wire logic pulse_edge, // Rising edge of the synchronised tach pin.
   input wire logic restart, // Preload write, restarts validity.
   input wire logic [CW-1:0] preload, // Start value of each count.
   output logic [CW-1:0] live_count, // Running count.
   output logic [CW-1:0] tach_count, // Count latched at pulse end.
   output logic valid // Latched count is trustworthy.
);
   logic [CW-1:0] live_reg;
   logic [CW-1:0] live_next;
   logic [CW-1:0] tach_reg;
   logic [CW-1:0] tach_next;
   logic [1:0] pulses_reg;
   logic [1:0] pulses_next;

   always_comb begin
      live_next = live_reg;
      tach_next = tach_reg;
      pulses_next = pulses_reg;
      if (pulse_edge) begin
         tach_next = live_reg;
         live_next = preload;
         if (pulses_reg != `FANTM_VALID_PULSES) begin
            pulses_next = pulses_reg + 2'h1;
         end
      end else if (tick && live_reg != CW'(`FANTM_TACH_MAX)) begin
         live_next = live_reg + 1'b1;
      end
      // The pulse in flight began under the old preload, so two edges are needed.
      if (restart) begin
         pulses_next = 2'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         live_reg <= CW'(`FANTM_TACH_RST);
         tach_reg <= CW'(`FANTM_TACH_RST);
         pulses_reg <= 2'h0;
      end else begin
         live_reg <= live_next;
         tach_reg <= tach_next;
         pulses_reg <= pulses_next;
      end
   end

   assign live_count = live_reg;
   assign tach_count = tach_reg;
   assign valid = (pulses_reg == `FANTM_VALID_PULSES);
endmodule : fantm_tach_counter

//--- verif/fantm_fan_model.sv
`timescale 1ns/1ps
// ****************************************
// Two fans producing tach pulses
// ****************************************
module fantm_fan_model (
   input wire logic pclk, // Clock that paces the pulses.
   input wire logic presetn, // Fans held still while low.
   input wire logic [1:0][15:0] period, // Pulse period in cycles, fan one at index 0.
   output logic [1:0] fan_tach // Tach pins, fan one at bit 0.
);
   // A new period is taken only at a pulse boundary, so no pulse is ever cut short.
   for (genvar g = 0; g < 2; g++) begin : g_fan
      int cnt;
      int cur;
      always @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt <= 0;
            cur <= int'(period[g]);
            fan_tach[g] <= 1'b0;
         end else begin
            if (cnt + 1 >= cur) begin
               cnt <= 0;
               cur <= int'(period[g]);
            end else begin
               cnt <= cnt + 1;
            end
            fan_tach[g] <= (cnt < cur / 2);
         end
      end
   end
endmodule : fantm_fan_model

//--- verif/fan_tachometer_monitor_tb.sv
`timescale 1ns/1ps
`include "fantm_defs.svh"
module fan_tachometer_monitor_tb;
   typedef struct {
      string name;
      logic [31:0] exp;
      int tol;
      logic err;
   } fantm_exp_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] fan_tach;
   logic [1:0][15:0] fan_period = {16'h03e8, 16'h03e8};
   int failures = 0;
   int check_count = 0;
   int old_max = 1000;
   fantm_exp_t notes[$];

   always #2.5 pclk = ~pclk;

   // Base periods of 4, 8, 16 and 32 cycles keep the slowest settings inside the run budget.
   fantm_top #(.BASE_HZ0(50000000), .BASE_HZ1(25000000), .BASE_HZ2(12500000), .BASE_HZ3(6250000)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fan_tach(fan_tach));

   fantm_fan_model fans (.pclk(pclk), .presetn(presetn), .period(fan_period), .fan_tach(fan_tach));

   // ****************************************
   // Reporting and comparison
   // ****************************************
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   task automatic cmp_exact(input string name, input logic [31:0] exp, input logic [31:0] seen);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : cmp_exact

   task automatic cmp_range(input string name, input logic [31:0] exp, input int tol, input logic [31:0] seen);
      int lo;
      int hi;
      lo = (int'(exp) > tol) ? int'(exp) - tol : 0;
      hi = (int'(exp) + tol > 255) ? 255 : int'(exp) + tol;
      check_count++;
      if (!((^seen !== 1'bx) && seen >= lo && seen <= hi)) begin
         failures++;
         $display("[ERR] %s expected %0d+-%0d seen %h", name, exp, tol, seen);
      end
   endtask : cmp_range

   always @(posedge pclk) begin : monitor
      fantm_exp_t e;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (notes.size() == 0) begin
            failures++;
            $display("[ERR] read expected none seen %h", prdata);
         end else begin
            e = notes.pop_front();
            cmp_exact({e.name, " error"}, {31'h0, e.err}, {31'h0, pslverr});
            if (e.tol == 0) begin
               cmp_exact(e.name, e.exp, prdata);
            end else begin
               cmp_range(e.name, e.exp, e.tol, prdata);
            end
         end
      end
   end

   // ****************************************
   // Bus and fan helpers
   // ****************************************
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         failures++;
         $display("[ERR] pready expected 1 seen %b", pready);
         report_and_stop();
      end
   endtask : apb

   task automatic rd(input string name, input logic [7:0] a, input int exp, input int tol, input logic err);
      fantm_exp_t e;
      e.name = name;
      e.exp = (exp > 255) ? 32'h0000_00ff : exp;
      e.tol = tol;
      e.err = err;
      notes.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // Waits out the pulse in flight plus three new periods, so two whole pulses are latched.
   task automatic settle(input int p1, input int p2);
      int m;
      m = (p1 > p2) ? p1 : p2;
      fan_period <= {p2[15:0], p1[15:0]};
      repeat (old_max + 3 * m + 20) @(posedge pclk);
      old_max = m;
   endtask : settle

   function automatic int tick_per(input logic src, input logic sel, input logic mul, input logic [1:0] dv);
      int b;
      b = 4 << {src, sel};
      return (b >> mul) << dv;
   endfunction : tick_per

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin : main
      int tp1;
      int tp2;
      int n1;
      int n2;
      logic [7:0] cfg;
      logic [31:0] r;
      void'($urandom(11845));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd("cfg", `FANTM_OFF_CFG, 32'h50, 0, 1'b0);
      rd("tach1", `FANTM_OFF_TACH1, 0, 0, 1'b0);
      rd("tach2", `FANTM_OFF_TACH2, 0, 0, 1'b0);
      rd("status", `FANTM_OFF_STATUS, 0, 0, 1'b0);
      apb(1'b1, `FANTM_OFF_TACH1, 32'h0000_00aa);
      apb(1'b1, 8'h1c, 32'h0000_00ff);
      rd("tach1 ro", `FANTM_OFF_TACH1, 0, 0, 1'b0);
      rd("unmapped", 8'h18, 0, 0, 1'b1);
      rd("cfg kept", `FANTM_OFF_CFG, 32'h50, 0, 1'b0);
      $display("test reset_and_access finished");
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         cfg = {2'(3 - i), 2'(i), ~i[2], i[2], r[1:0]};
         apb(1'b1, `FANTM_OFF_CFG, {24'h0, cfg});
         apb(1'b1, `FANTM_OFF_SEL, {30'h0, r[5:4]});
         tp1 = tick_per(cfg[0], r[4], cfg[2], cfg[5:4]);
         tp2 = tick_per(cfg[1], r[5], cfg[3], cfg[7:6]);
         n1 = 4 + $urandom % 8;
         n2 = 4 + $urandom % 8;
         settle(tp1 * n1, tp2 * n2);
         rd("cfg rw", `FANTM_OFF_CFG, cfg, 0, 1'b0);
         rd("sel rw", `FANTM_OFF_SEL, r[5:4], 0, 1'b0);
         rd("tach1 rate", `FANTM_OFF_TACH1, n1, 1, 1'b0);
         rd("tach2 rate", `FANTM_OFF_TACH2, n2, 1, 1'b0);
      end
      $display("test rate_settings finished");
      apb(1'b1, `FANTM_OFF_CFG, 32'h0000_0050);
      apb(1'b1, `FANTM_OFF_SEL, 32'h0);
      settle(8 * 300, 8 * 20);
      rd("tach1 sat", `FANTM_OFF_TACH1, 255, 0, 1'b0);
      rd("tach2 plain", `FANTM_OFF_TACH2, 20, 1, 1'b0);
      $display("test saturation finished");
      apb(1'b1, `FANTM_OFF_PRELOAD, 32'h0000_0003);
      rd("status cleared", `FANTM_OFF_STATUS, 0, 0, 1'b0);
      settle(8 * 300, 8 * 20);
      rd("status valid", `FANTM_OFF_STATUS, 3, 0, 1'b0);
      rd("tach2 preload", `FANTM_OFF_TACH2, 23, 1, 1'b0);
      rd("tach1 preload", `FANTM_OFF_TACH1, 255, 0, 1'b0);
      rd("preload rw", `FANTM_OFF_PRELOAD, 3, 0, 1'b0);
      settle(8 * 20, 8 * 300);
      rd("tach1 short", `FANTM_OFF_TACH1, 23, 1, 1'b0);
      rd("tach2 sat", `FANTM_OFF_TACH2, 255, 0, 1'b0);
      $display("test preload finished");
      repeat (5) @(posedge pclk);
      if (notes.size() != 0) begin
         failures++;
         $display("[ERR] pending reads expected 0 seen %0d", notes.size());
      end
      report_and_stop();
   end
endmodule : fan_tachometer_monitor_tb
